/* ces_link_master.sv */
// Purpose: Far-side network master that stops answering on request.
// Assumes: Shares mclk with the supervisor.
// Notes: A silent master shows up as a level link fault one edge later.
`timescale 1ns/1ps
`default_nettype none
module ces_link_master
(
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst,
    // Bench control and link status.
    input wire logic cutLink,
    output logic lineFault
);
    // Registered so that faults start and end on clean edges, as a real loss would.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            lineFault <= 1'b0;
        else
            lineFault <= cutLink;
    end
endmodule // ces_link_master
`default_nettype wire

/* ces_pkg.sv */
// Purpose: Shared constants and carriers for the communication error supervisor.
// Assumes: One 200 MHz clock; register port with read data one cycle after the strobe.
// Notes: Times are given in their own unit and converted to cycles here.
package ces_pkg;

    // Register offsets (byte addresses, one 32-bit word each).
    localparam logic [7:0] ADDR_WAIT_TIME = 8'h00;
    localparam logic [7:0] ADDR_ERR_COUNT = 8'h04;
    localparam logic [7:0] ADDR_STOP_POLICY = 8'h08;
    localparam logic [7:0] ADDR_FALLBACK_FREQ = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_CONTROL = 8'h14;
    localparam logic [7:0] ADDR_SAVED_COUNT = 8'h18;

    // Values after reset, and the fallback frequency limit.
    localparam logic [15:0] RST_WAIT_TIME = 16'h0000;
    localparam logic [15:0] RST_ERR_COUNT = 16'h0000;
    localparam logic [3:0] RST_STOP_POLICY = 4'h0;
    localparam logic [15:0] FALLBACK_KEEP = 16'h270F;
    localparam logic [15:0] FALLBACK_MAX = 16'h024E;

    // Fault data codes.
    localparam logic [7:0] FAULT_CODE_LINE = 8'hA1;
    localparam logic [7:0] FAULT_CODE_OPTION = 8'hF1;
    localparam logic [7:0] FAULT_CODE_NONE = 8'h00;

    // Timing: clock rate, wait-time unit and nonvolatile save interval.
    localparam int CLK_HZ = 200000000;
    localparam int WAIT_UNIT_MS = 100;
    localparam int WAIT_UNIT_CYCLES = CLK_HZ / 1000 * WAIT_UNIT_MS;
    localparam int SAVE_INTERVAL_S = 3600;
    localparam longint SAVE_INTERVAL_CYCLES = longint'(CLK_HZ) * SAVE_INTERVAL_S;

    // Status bit positions.
    localparam int ST_LINE_FAULT = 0;
    localparam int ST_COMM_ERROR = 1;
    localparam int ST_TRIPPED = 2;
    localparam int ST_WARNING = 3;
    localparam int ST_DECEL = 4;
    localparam int ST_SHUTOFF = 5;
    localparam int ST_HIST_TEMP = 6;

    // Supervisor states.
    typedef enum logic [2:0]
    {
        CES_RUN = 3'b000,
        CES_DECEL = 3'b001,
        CES_SHUTOFF = 3'b010,
        CES_CONTINUE = 3'b011,
        CES_STOPPED = 3'b100
    } ces_state_t;

    // Drive command carried to the motor controller.
    typedef struct packed
    {
        logic run;
        logic shutoff;
        logic decel;
        logic [1:0] decelSel;
        logic [15:0] freq;
    } ces_drive_t;

    // Fault indication bundle.
    typedef struct packed
    {
        logic alarm;
        logic faultBit;
        logic warning;
        logic [7:0] code;
    } ces_fault_t;

endpackage

/* ces_supervisor.sv */
// Purpose: Decides the drive reaction to a network link loss or a communication option fault.
// Assumes: All inputs synchronous to mclk; register port never stalls.
// Notes: Nonvolatile storage is modelled by a save strobe and a restore input sampled after reset.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Reaction settings, except the decel select of policies 11 and 12, act only while the drive is in network operation mode.
// - A line fault becomes an error only after persisting beyond the wait time.
// - A fault clearing inside the wait time raises nothing and operation continues.
// - Each line fault onset in network mode adds one to the error count.
// - The count runs 0 to 65535 and wraps to zero.
// - Writing zero to the count register clears it.
// - Count is saved hourly and restored from the last saved copy after reset.
// - Stop policy accepts 0 to 4, 11 and 12, reset value 0.
// - Fallback frequency up to 590 Hz is used in error for policy 3 or 4.
// - Fallback code 9999 keeps the frequency commanded before the error.
// - Option fault: shutoff for 0,3; decel then trip for 1,2,11,12; warn for 4.
// - Option faults act at once, ignoring the wait time.
// - Position control with continue policies keeps moving to target.
// - Policies 1-4 use selected decel time; 11 and 12 use third decel time.
// - Policies 1-4 apply the normal deceleration time selection.
// - Without position control, policy 2 or 12 re-accelerates if the line error clears while decelerating.
// - Restart uses the live run and speed commands with normal acceleration.
// - No restart when the cleared fault was an option fault.
// - Line errors carry code HA1, option faults code HF1.
// - The fault output drives both alarm output and fault status bit.
// - Asserted fault output writes a permanent history entry.
// - Without fault output the history entry is temporary and restored on clear.
module ces_supervisor #(
    parameter longint SAVE_CYCLES = ces_pkg::SAVE_INTERVAL_CYCLES,
    parameter int WAIT_UNIT = ces_pkg::WAIT_UNIT_CYCLES
)
(
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst,
    // Register port.
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdata,
    // Drive context.
    input wire logic netMode,
    input wire logic positionControl,
    input wire logic second_function_select,
    input wire logic third_function_select,
    input wire logic runCmd,
    input wire logic [15:0] speedCmd,
    input wire logic drive_reset_input,
    // Fault sources.
    input wire logic lineFault,
    input wire logic optionFault,
    input wire logic motorStopped,
    // Nonvolatile copy of the count.
    input wire logic [15:0] nvCount,
    output logic nvSave,
    output logic [15:0] nvSaveData,
    // Drive reaction.
    output ces_pkg::ces_drive_t drive,
    output ces_pkg::ces_fault_t fault,
    output logic alarm_output,
    output logic histWrite,
    output logic histPermanent,
    output logic histRestore
);

    ces_pkg::ces_state_t state;
    logic [15:0] waitTime;
    logic [15:0] errCount;
    logic [3:0] stopPolicy;
    logic [15:0] fallbackFreq;
    logic [15:0] heldSpeed;
    logic heldRun;
    logic linePrev;
    logic [63:0] waitCnt;
    logic commError;
    logic optLatched;
    logic restoreDone;
    logic [63:0] saveCnt;
    logic histTemp;
    logic [15:0] wrCount;
    logic lineOnset;
    logic errEvent;
    logic optEvent;
    logic tripLatch;

    // Policy decoding used only by the reaction state machine.
    function automatic logic isDecel(input logic [3:0] p);
        isDecel = (p == 4'h1) || (p == 4'h2) || (p == 4'hB) || (p == 4'hC);
    endfunction

    function automatic logic isRestart(input logic [3:0] p);
        isRestart = (p == 4'h2) || (p == 4'hC);
    endfunction

    assign lineOnset = lineFault && !linePrev;
    assign wrCount = regWdata[15:0];
    // The product is formed in 64 bits: a full-scale wait time at the real unit overflows 32 bits.
    assign errEvent = lineFault && (waitCnt >= 64'(waitTime) * 64'(WAIT_UNIT)) && !commError;
    assign optEvent = optionFault && !optLatched;

    // Register writes; values out of range are refused so the old setting stays.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            waitTime <= ces_pkg::RST_WAIT_TIME;
            stopPolicy <= ces_pkg::RST_STOP_POLICY;
            fallbackFreq <= ces_pkg::FALLBACK_KEEP;
        end
        else if (regWrite)
        begin
            if (regAddr == ces_pkg::ADDR_WAIT_TIME)
                waitTime <= regWdata[15:0];
            if (regAddr == ces_pkg::ADDR_STOP_POLICY && (regWdata[3:0] <= 4'h4 || regWdata[3:0] == 4'hB
                || regWdata[3:0] == 4'hC) && regWdata[31:4] == 28'h0000000)
                stopPolicy <= regWdata[3:0];
            if (regAddr == ces_pkg::ADDR_FALLBACK_FREQ && (regWdata[15:0] <= ces_pkg::FALLBACK_MAX
                || regWdata[15:0] == ces_pkg::FALLBACK_KEEP))
                fallbackFreq <= regWdata[15:0];
        end
    end

    // Error count: onset increments, 16 bits wrap naturally, zero write clears, reload after reset.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            errCount <= ces_pkg::RST_ERR_COUNT;
            restoreDone <= 1'b0;
        end
        else if (!restoreDone)
        begin
            errCount <= nvCount;
            restoreDone <= 1'b1;
        end
        else if (lineOnset && netMode)
            errCount <= errCount + 16'h0001;
        else if (regWrite && regAddr == ces_pkg::ADDR_ERR_COUNT && wrCount == 16'h0000)
            errCount <= 16'h0000;
    end

    // Hourly save of the count to nonvolatile storage.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            saveCnt <= 64'h0000000000000000;
            nvSave <= 1'b0;
            nvSaveData <= 16'h0000;
        end
        else
        begin
            nvSave <= 1'b0;
            if (saveCnt >= 64'(SAVE_CYCLES - 1))
            begin
                saveCnt <= 64'h0000000000000000;
                nvSave <= 1'b1;
                nvSaveData <= errCount;
            end
            else
                saveCnt <= saveCnt + 64'h0000000000000001;
        end
    end

    // Wait timer; it restarts at each onset and is cleared while the link is healthy.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            linePrev <= 1'b0;
            waitCnt <= 64'h0000000000000000;
        end
        else
        begin
            linePrev <= lineFault;
            if (!lineFault || lineOnset)
                waitCnt <= 64'h0000000000000000;
            else if (waitCnt != 64'hFFFFFFFFFFFFFFFF)
                waitCnt <= waitCnt + 64'h0000000000000001;
        end
    end

    // Held commands, frozen once an error is declared so the continue state can reuse them.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            heldRun <= 1'b0;
            heldSpeed <= 16'h0000;
        end
        else if (state == ces_pkg::CES_RUN && !commError)
        begin
            heldRun <= runCmd;
            heldSpeed <= speedCmd;
        end
    end

    // Reaction state machine; only active in network mode.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            state <= ces_pkg::CES_RUN;
            commError <= 1'b0;
            optLatched <= 1'b0;
            tripLatch <= 1'b0;
            fault.code <= ces_pkg::FAULT_CODE_NONE;
            fault.warning <= 1'b0;
        end
        else if (drive_reset_input || !netMode)
        begin
            state <= ces_pkg::CES_RUN;
            commError <= 1'b0;
            optLatched <= 1'b0;
            tripLatch <= 1'b0;
            fault.code <= ces_pkg::FAULT_CODE_NONE;
            fault.warning <= 1'b0;
        end
        else
        begin
            unique case (state)
                ces_pkg::CES_RUN:
                begin
                    if (optEvent)
                    begin
                        optLatched <= 1'b1;
                        fault.code <= ces_pkg::FAULT_CODE_OPTION;
                        if (stopPolicy == 4'h4)
                        begin
                            state <= ces_pkg::CES_CONTINUE;
                            fault.warning <= 1'b1;
                        end
                        else if (isDecel(stopPolicy))
                            state <= ces_pkg::CES_DECEL;
                        else
                        begin
                            state <= ces_pkg::CES_SHUTOFF;
                            tripLatch <= 1'b1;
                        end
                    end
                    else if (errEvent)
                    begin
                        commError <= 1'b1;
                        fault.code <= ces_pkg::FAULT_CODE_LINE;
                        if (stopPolicy == 4'h0)
                        begin
                            state <= ces_pkg::CES_SHUTOFF;
                            tripLatch <= 1'b1;
                        end
                        else if (stopPolicy == 4'h3 || stopPolicy == 4'h4)
                        begin
                            state <= ces_pkg::CES_CONTINUE;
                            fault.warning <= (stopPolicy == 4'h4);
                        end
                        else
                            state <= ces_pkg::CES_DECEL;
                    end
                end
                ces_pkg::CES_DECEL:
                begin
                    if (commError && !lineFault && isRestart(stopPolicy) && !optLatched && !positionControl)
                    begin
                        state <= ces_pkg::CES_RUN;
                        commError <= 1'b0;
                        fault.code <= ces_pkg::FAULT_CODE_NONE;
                    end
                    else if (motorStopped)
                    begin
                        state <= ces_pkg::CES_STOPPED;
                        tripLatch <= 1'b1;
                    end
                end
                ces_pkg::CES_STOPPED:
                begin
                    if (commError && !lineFault && isRestart(stopPolicy))
                    begin
                        state <= ces_pkg::CES_RUN;
                        commError <= 1'b0;
                        tripLatch <= 1'b0;
                        fault.code <= ces_pkg::FAULT_CODE_NONE;
                    end
                end
                ces_pkg::CES_CONTINUE:
                begin
                    if (commError && !lineFault)
                    begin
                        state <= ces_pkg::CES_RUN;
                        commError <= 1'b0;
                        fault.warning <= 1'b0;
                        fault.code <= ces_pkg::FAULT_CODE_NONE;
                    end
                end
                ces_pkg::CES_SHUTOFF:
                begin
                    state <= ces_pkg::CES_SHUTOFF;
                end
                default:
                begin
                    state <= ces_pkg::CES_SHUTOFF;
                end
            endcase
        end
    end

    // Drive command; fallback only applies to continue policies, position control keeps the target.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            drive <= '0;
        end
        else
        begin
            drive.run <= (state == ces_pkg::CES_RUN) ? runCmd : (state == ces_pkg::CES_CONTINUE) ? heldRun : 1'b0;
            drive.shutoff <= (state == ces_pkg::CES_SHUTOFF);
            drive.decel <= (state == ces_pkg::CES_DECEL) || (state == ces_pkg::CES_STOPPED);
            // Third deceleration time is code 3; otherwise the selects choose, code 0 being normal.
            if (stopPolicy == 4'hB || stopPolicy == 4'hC)
                drive.decelSel <= 2'h3;
            else
                drive.decelSel <= third_function_select ? 2'h2 : second_function_select ? 2'h1 : 2'h0;
            if (state == ces_pkg::CES_CONTINUE && !positionControl && fallbackFreq != ces_pkg::FALLBACK_KEEP)
                drive.freq <= fallbackFreq;
            else if (state == ces_pkg::CES_CONTINUE)
                drive.freq <= heldSpeed;
            else
                drive.freq <= speedCmd;
        end
    end

    // Fault output and history; a trip writes a permanent entry, a warning only a temporary one.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            fault.alarm <= 1'b0;
            fault.faultBit <= 1'b0;
            alarm_output <= 1'b0;
            histWrite <= 1'b0;
            histPermanent <= 1'b0;
            histRestore <= 1'b0;
            histTemp <= 1'b0;
        end
        else
        begin
            fault.alarm <= tripLatch;
            fault.faultBit <= tripLatch;
            alarm_output <= tripLatch;
            histWrite <= 1'b0;
            histRestore <= 1'b0;
            if (tripLatch && !fault.alarm)
            begin
                histWrite <= 1'b1;
                histPermanent <= 1'b1;
                histTemp <= 1'b0;
            end
            else if (state == ces_pkg::CES_CONTINUE && !histTemp && !tripLatch)
            begin
                histWrite <= 1'b1;
                histPermanent <= 1'b0;
                histTemp <= 1'b1;
            end
            else if (histTemp && state == ces_pkg::CES_RUN)
            begin
                histRestore <= 1'b1;
                histTemp <= 1'b0;
            end
        end
    end

    // Register read data, one cycle after the strobe.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            regRdata <= 32'h00000000;
        else if (regRead)
        begin
            unique case (regAddr)
                ces_pkg::ADDR_WAIT_TIME: regRdata <= {16'h0000, waitTime};
                ces_pkg::ADDR_ERR_COUNT: regRdata <= {16'h0000, errCount};
                ces_pkg::ADDR_STOP_POLICY: regRdata <= {28'h0000000, stopPolicy};
                ces_pkg::ADDR_FALLBACK_FREQ: regRdata <= {16'h0000, fallbackFreq};
                ces_pkg::ADDR_STATUS: regRdata <= {25'h0000000, histTemp, drive.shutoff, drive.decel,
                    fault.warning, tripLatch, commError, lineFault};
                ces_pkg::ADDR_SAVED_COUNT: regRdata <= {16'h0000, nvSaveData};
                default: regRdata <= 32'h00000000;
            endcase
        end
        else
            regRdata <= 32'h00000000;
    end

    // Checks.
    sequence s_onset;
        lineFault && !linePrev && netMode && restoreDone;
    endsequence

    AST_COUNT_INC: assert property (@(posedge mclk) disable iff (rst)
        s_onset |=> errCount == $past(errCount) + 16'h0001)
        else $error("count did not advance on fault onset");
    AST_NO_EARLY: assert property (@(posedge mclk) disable iff (rst)
        !lineFault && !$past(commError) && netMode |=> !commError)
        else $error("error declared while link healthy");
    AST_OPT_SHUT: assert property (@(posedge mclk) disable iff (rst)
        state == ces_pkg::CES_RUN && optEvent && netMode && !drive_reset_input && stopPolicy == 4'h0
        |=> state == ces_pkg::CES_SHUTOFF)
        else $error("option fault did not shut off output");
    AST_ALARM_PAIR: assert property (@(posedge mclk) disable iff (rst)
        alarm_output == fault.faultBit)
        else $error("alarm and fault bit differ");
    AST_ALARM_FOLLOW: assert property (@(posedge mclk) disable iff (rst)
        $rose(tripLatch) |=> alarm_output)
        else $error("alarm not raised after trip");
    AST_HIST_PERM: assert property (@(posedge mclk) disable iff (rst)
        $rose(alarm_output) |-> histWrite && histPermanent)
        else $error("trip without permanent history write");
    AST_POLICY_RANGE: assert property (@(posedge mclk) disable iff (rst)
        stopPolicy <= 4'h4 || stopPolicy == 4'hB || stopPolicy == 4'hC)
        else $error("illegal stop policy stored");
    AST_CLEAR: assert property (@(posedge mclk) disable iff (rst)
        regWrite && regAddr == ces_pkg::ADDR_ERR_COUNT && wrCount == 16'h0000 && restoreDone && !lineOnset
        |=> errCount == 16'h0000)
        else $error("count not cleared by zero write");
    AST_SHUT_HOLD: assert property (@(posedge mclk) disable iff (rst)
        state == ces_pkg::CES_SHUTOFF && !drive_reset_input && netMode |=> state == ces_pkg::CES_SHUTOFF)
        else $error("shutoff left without fault reset");

endmodule // ces_supervisor

`default_nettype wire

/* comm_error_supervisor_bench.sv */
// Purpose: Self-checking bench for the communication error supervisor.
// Assumes: Short wait unit of 4 cycles and save interval of 100 cycles.
// Notes: Count wrap is left to the design's own assertions; 65536 onsets are too long here.
`timescale 1ns/1ps
`default_nettype none
module comm_error_supervisor_bench;
    logic mclk, rst, regWrite, regRead, netMode, positionControl, secondSel, thirdSel;
    logic runCmd, driveReset, optionFault, motorStopped, cutLink, lineFault;
    logic nvSave, histWrite, histPermanent, histRestore, alarmOut;
    logic [7:0] regAddr;
    logic [31:0] regWdata, regRdata;
    logic [15:0] speedCmd, nvCount, nvSaveData;
    ces_pkg::ces_drive_t drive;
    ces_pkg::ces_fault_t fault;
    int mismatches = 0;
    int checks = 0;

    ces_link_master link_u (.mclk(mclk), .rst(rst), .cutLink(cutLink), .lineFault(lineFault));
    ces_supervisor #(.SAVE_CYCLES(100), .WAIT_UNIT(4)) dut_u (.mclk(mclk), .rst(rst),
        .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
        .regRdata(regRdata), .netMode(netMode), .positionControl(positionControl),
        .second_function_select(secondSel), .third_function_select(thirdSel), .runCmd(runCmd),
        .speedCmd(speedCmd), .drive_reset_input(driveReset), .lineFault(lineFault),
        .optionFault(optionFault), .motorStopped(motorStopped), .nvCount(nvCount), .nvSave(nvSave),
        .nvSaveData(nvSaveData), .drive(drive), .fault(fault), .alarm_output(alarmOut),
        .histWrite(histWrite), .histPermanent(histPermanent), .histRestore(histRestore));

    // Free-running 200 MHz clock.
    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // Compares a seen value to an expected one and counts the result.
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One-cycle register write.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge mclk);
        regWrite <= 1'b0;
    endtask

    // One-cycle register read; data stand only in the following cycle.
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge mclk);
        regRead <= 1'b0;
        #1 d = regRdata;
    endtask

    // Holds the link down for n cycles, then restores it.
    task automatic link_down(input int n);
        @(posedge mclk);
        cutLink <= 1'b1;
        repeat (n) @(posedge mclk);
        cutLink <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask

    // Pulses the fault reset so that the next scenario starts clean.
    task automatic clear_all();
        @(posedge mclk);
        driveReset <= 1'b1;
        @(posedge mclk);
        driveReset <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask

    // Restored count, default policy, and counting of onsets after a clear.
    task automatic test_count();
        logic [31:0] d;
        rd(ces_pkg::ADDR_ERR_COUNT, d);
        check(d, 32'h0000_0005);
        rd(ces_pkg::ADDR_STOP_POLICY, d);
        check(d, 32'h0000_0000);
        wr(ces_pkg::ADDR_ERR_COUNT, 32'h0000_0000);
        rd(ces_pkg::ADDR_ERR_COUNT, d);
        check(d, 32'h0000_0000);
        wr(ces_pkg::ADDR_WAIT_TIME, 32'h0000_0002);
        link_down(3);
        link_down(3);
        rd(ces_pkg::ADDR_ERR_COUNT, d);
        check(d, 32'h0000_0002);
        rd(ces_pkg::ADDR_STATUS, d);
        check({31'h0, d[ces_pkg::ST_COMM_ERROR]}, 32'h0);
        check({31'h0, alarmOut}, 32'h0);
    endtask

    // Policy 0: a long fault shuts off, trips with the line code and stays tripped.
    task automatic test_shutoff();
        logic [31:0] d;
        @(posedge mclk);
        cutLink <= 1'b1;
        repeat (14) @(posedge mclk);
        #1 check({31'h0, drive.shutoff}, 32'h1);
        check({24'h0, fault.code}, {24'h0, ces_pkg::FAULT_CODE_LINE});
        check({30'h0, alarmOut, fault.faultBit}, 32'h3);
        @(posedge mclk);
        cutLink <= 1'b0;
        repeat (6) @(posedge mclk);
        rd(ces_pkg::ADDR_STATUS, d);
        check({31'h0, d[ces_pkg::ST_TRIPPED]}, 32'h1);
        check({31'h0, alarmOut}, 32'h1);
        clear_all();
        #1 check({31'h0, alarmOut}, 32'h0);
    endtask

    // Policy 3: the drive keeps running at the fallback frequency without a trip.
    task automatic test_fallback();
        wr(ces_pkg::ADDR_STOP_POLICY, 32'h0000_0003);
        wr(ces_pkg::ADDR_FALLBACK_FREQ, 32'h0000_0032);
        @(posedge mclk);
        cutLink <= 1'b1;
        repeat (14) @(posedge mclk);
        #1 check({15'h0, drive.freq, drive.shutoff}, {15'h0, 16'h0032, 1'b0});
        check({31'h0, alarmOut}, 32'h0);
        @(posedge mclk);
        cutLink <= 1'b0;
        clear_all();
    endtask

    // Policy 0: an option fault shuts off at once with the option code.
    task automatic test_option();
        wr(ces_pkg::ADDR_STOP_POLICY, 32'h0000_0000);
        @(posedge mclk);
        optionFault <= 1'b1;
        repeat (3) @(posedge mclk);
        #1 check({31'h0, drive.shutoff}, 32'h1);
        check({24'h0, fault.code}, {24'h0, ces_pkg::FAULT_CODE_OPTION});
        @(posedge mclk);
        optionFault <= 1'b0;
        clear_all();
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Watchdog: the whole sequence needs well under 1000 cycles.
    initial
    begin
        #100us;
        mismatches++;
        print_verdict();
    end

    // Main sequence.
    initial
    begin
        rst = 1'b1;
        {regWrite, regRead, positionControl, secondSel, thirdSel, driveReset} = 6'h00;
        {optionFault, motorStopped, cutLink} = 3'h0;
        {netMode, runCmd} = 2'h3;
        regAddr = 8'h00;
        regWdata = 32'h0;
        speedCmd = 16'h0064;
        nvCount = 16'h0005;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        repeat (3) @(posedge mclk);
        test_count();
        test_shutoff();
        test_fallback();
        test_option();
        // Four onsets have been counted since the clear; the next save, every 100 cycles here, must carry them.
        @(posedge nvSave);
        #1 check({16'h0, nvSaveData}, 32'h0000_0004);
        print_verdict();
    end
endmodule // comm_error_supervisor_bench
`default_nettype wire
